// ===== src/tccp_pkg.sv
// Shared constants for the capture/compare register pair
package tccp_pkg;
	// Data and address widths of the register port
	localparam int unsigned DATA_W = 16;
	localparam int unsigned ADDR_W = 5;

	// Register byte offsets
	localparam logic [4:0] OFS_CC_FIRST = 5'h00;
	localparam logic [4:0] OFS_CC_SECOND = 5'h04;
	localparam logic [4:0] OFS_CC_CONTROL = 5'h08;
	localparam logic [4:0] OFS_PRESCALER_MODE = 5'h0C;
	localparam logic [4:0] OFS_STATUS = 5'h10;

	// Reset values
	localparam logic [15:0] CC_RESET = 16'h0000;
	localparam logic [2:0] CTRL_RESET = 3'h0;
	localparam logic [3:0] EDGE_RESET = 4'h0;

	// Capture control field positions
	localparam int unsigned BIT_FIRST_ROLE = 0;
	localparam int unsigned BIT_FIRST_TRIG = 1;
	localparam int unsigned BIT_SECOND_ROLE = 2;

	// Prescaler mode field positions: first input code 5:4, second 7:6
	localparam int unsigned BIT_EDGE_FIRST_LO = 4;
	localparam int unsigned BIT_EDGE_SECOND_LO = 6;

	// Counter mode field, upper two bits of the three-bit mode
	localparam logic [1:0] MODE_STOP = 2'h0;
	localparam logic [1:0] MODE_FREE = 2'h1;
	localparam logic [1:0] MODE_CLR_EDGE = 2'h2;
	localparam logic [1:0] MODE_CLR_MATCH = 2'h3;

	// Edge-select codes
	localparam logic [1:0] EDGE_FALL = 2'h0;
	localparam logic [1:0] EDGE_RISE = 2'h1;
	localparam logic [1:0] EDGE_BAD = 2'h2;
	localparam logic [1:0] EDGE_BOTH = 2'h3;

	// Count values of interest
	localparam logic [15:0] COUNT_ZERO = 16'h0000;
	localparam logic [15:0] COUNT_TOP = 16'hFFFF;
endpackage : tccp_pkg

// ===== src/tccp_pin_sync.sv
// Three-stage pin synchroniser with filtered level and edge pulses
`timescale 1ns/1ns
`default_nettype none
module tccp_pin_sync (
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic pin_in,
	output logic level,
	output logic rise,
	output logic fall
);
	logic s1_reg;
	logic s2_reg;
	logic s3_reg;

	// First stage feeds only the second; level moves when stages 2 and 3 agree
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			s1_reg <= 1'b0;
			s2_reg <= 1'b0;
			s3_reg <= 1'b0;
		end
		else
		begin
			s1_reg <= pin_in;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
		end
	end

	// Filtered level with one-cycle edge pulses
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			level <= 1'b0;
			rise <= 1'b0;
			fall <= 1'b0;
		end
		else
		begin
			rise <= (s2_reg == s3_reg) && s3_reg && !level;
			fall <= (s2_reg == s3_reg) && !s3_reg && level;
			if (s2_reg == s3_reg)
			begin
				level <= s3_reg;
			end
		end
	end
endmodule : tccp_pin_sync
`default_nettype wire

// ===== src/tccp_edge_sel.sv
// Turns an edge-select code and synchronised edges into a trigger
`timescale 1ns/1ns
`default_nettype none
module tccp_edge_sel (
	input wire logic rise,
	input wire logic fall,
	input wire logic [1:0] code,
	input wire logic reverse,
	output logic hit
);
	// Reverse phase swaps the edges and drops the both-edge setting;
	// the prohibited code never triggers, so a bad write is harmless
	always_comb
	begin
		hit = 1'b0;
		unique case (code)
			tccp_pkg::EDGE_FALL: hit = reverse ? rise : fall;
			tccp_pkg::EDGE_RISE: hit = reverse ? fall : rise;
			tccp_pkg::EDGE_BOTH: hit = reverse ? 1'b0 : (rise | fall);
			tccp_pkg::EDGE_BAD: hit = 1'b0;
		endcase
	end
endmodule : tccp_edge_sel
`default_nettype wire

// ===== src/tccp_top.sv
// Capture/compare register pair beside a 16-bit up-counter
`timescale 1ns/1ns
`default_nettype none
module tccp_top (
	input wire logic sys_clk,
	input wire logic arst_n,
	// Register port
	input wire logic [tccp_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [tccp_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [tccp_pkg::DATA_W-1:0] reg_rdata,
	// Counter side
	input wire logic [15:0] up_counter,
	input wire logic count_tick,
	input wire logic [2:0] timer_mode,
	// Timer inputs and shared pin
	input wire logic timer_input_first,
	input wire logic shared_port_pin_in,
	input wire logic timer_out_level,
	input wire logic timer_out_en,
	output logic shared_port_pin_out,
	output logic shared_port_pin_oe,
	// Events
	output logic match_irq_first,
	output logic match_irq_second,
	output logic interval_end
);
	// Register state
	logic [15:0] cc_reg_first;
	logic [15:0] cc_reg_second;
	logic [2:0] cc_control_reg;
	logic [3:0] prescaler_mode_reg;
	logic wrapped_reg;
	logic cap_pend_first_reg;
	logic cap_pend_second_reg;
	logic rd_first_hit_reg;
	logic rd_second_hit_reg;

	// Decoded control
	logic [1:0] mode_hi;
	logic running;
	logic zero_match_ok;
	logic first_role_sel;
	logic first_trigger_sel;
	logic second_role_sel;
	logic [1:0] in_first_edge;
	logic [1:0] in_second_edge;

	// Pin side
	logic second_pin_gated;
	logic first_level;
	logic first_rise;
	logic first_fall;
	logic second_level;
	logic second_rise;
	logic second_fall;
	logic hit_first_rev;
	logic hit_second_dir;
	logic hit_first_dir;

	// Events
	logic cap_first;
	logic cap_second;
	logic cmp_first;
	logic cmp_second;

	// Bus decode
	logic wr_cc_first;
	logic wr_cc_second;
	logic wr_control;
	logic wr_prescaler;
	logic [15:0] rd_mux;

	// Control field views
	assign mode_hi = timer_mode[2:1];
	assign running = (mode_hi != tccp_pkg::MODE_STOP);
	assign first_role_sel = cc_control_reg[tccp_pkg::BIT_FIRST_ROLE];
	assign first_trigger_sel = cc_control_reg[tccp_pkg::BIT_FIRST_TRIG];
	assign second_role_sel = cc_control_reg[tccp_pkg::BIT_SECOND_ROLE];
	assign in_first_edge = prescaler_mode_reg[1:0];
	assign in_second_edge = prescaler_mode_reg[3:2];

	// The zero-value match after a wrap exists only where the counter
	// is not cleared by the first register itself
	assign zero_match_ok = (mode_hi == tccp_pkg::MODE_FREE) ||
		(mode_hi == tccp_pkg::MODE_CLR_EDGE);

	// Shared pin: when the output controller owns it, the second input
	// sees a steady low so no stray edge reaches the capture logic
	assign shared_port_pin_oe = timer_out_en;
	assign shared_port_pin_out = timer_out_en ? timer_out_level : 1'b0;
	assign second_pin_gated = timer_out_en ? 1'b0 : shared_port_pin_in;

	// Input synchronisers
	tccp_pin_sync u_sync_first (
		.sys_clk(sys_clk),
		.arst_n(arst_n),
		.pin_in(timer_input_first),
		.level(first_level),
		.rise(first_rise),
		.fall(first_fall)
	);

	tccp_pin_sync u_sync_second (
		.sys_clk(sys_clk),
		.arst_n(arst_n),
		.pin_in(second_pin_gated),
		.level(second_level),
		.rise(second_rise),
		.fall(second_fall)
	);

	// First input in reverse phase, feeding the first register
	tccp_edge_sel u_sel_first_rev (
		.rise(first_rise),
		.fall(first_fall),
		.code(in_first_edge),
		.reverse(1'b1),
		.hit(hit_first_rev)
	);

	// Second input used directly, feeding the first register
	tccp_edge_sel u_sel_second_dir (
		.rise(second_rise),
		.fall(second_fall),
		.code(in_second_edge),
		.reverse(1'b0),
		.hit(hit_second_dir)
	);

	// First input used directly, feeding the second register
	tccp_edge_sel u_sel_first_dir (
		.rise(first_rise),
		.fall(first_fall),
		.code(in_first_edge),
		.reverse(1'b0),
		.hit(hit_first_dir)
	);

	// Capture strobes; a stopped timer takes no trigger at all, and a
	// compare-mode register is never loaded from the counter
	assign cap_first = running && first_role_sel &&
		(first_trigger_sel ? hit_first_rev : hit_second_dir);
	assign cap_second = running && second_role_sel && hit_first_dir;

	// Compare happens on each count, against the value being left, so a
	// match lasts exactly one count and a zero value only hits after a wrap
	assign cmp_first = running && !first_role_sel && count_tick &&
		(up_counter == cc_reg_first) &&
		((cc_reg_first != tccp_pkg::COUNT_ZERO) ||
		(zero_match_ok && wrapped_reg));
	assign cmp_second = running && !second_role_sel && count_tick &&
		(up_counter == cc_reg_second) &&
		((cc_reg_second != tccp_pkg::COUNT_ZERO) ||
		(zero_match_ok && wrapped_reg));

	// Register write decode
	assign wr_cc_first = reg_wr && (reg_addr == tccp_pkg::OFS_CC_FIRST);
	assign wr_cc_second = reg_wr && (reg_addr == tccp_pkg::OFS_CC_SECOND);
	assign wr_control = reg_wr && (reg_addr == tccp_pkg::OFS_CC_CONTROL);
	assign wr_prescaler = reg_wr && (reg_addr == tccp_pkg::OFS_PRESCALER_MODE);

	// Wrap tracking: set on the count that leaves the top value, cleared
	// only when the timer stops, so it marks "counting after overflow"
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			wrapped_reg <= 1'b0;
		end
		else if (!running)
		begin
			wrapped_reg <= 1'b0;
		end
		else if (count_tick && (up_counter == tccp_pkg::COUNT_TOP))
		begin
			wrapped_reg <= 1'b1;
		end
	end

	// First capture/compare register; a capture beats a write in the same
	// cycle because the latched count is the event software waits for
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			cc_reg_first <= tccp_pkg::CC_RESET;
		end
		else if (cap_first)
		begin
			cc_reg_first <= up_counter;
		end
		else if (wr_cc_first)
		begin
			cc_reg_first <= reg_wdata;
		end
	end

	// Second capture/compare register, written only as a whole word
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			cc_reg_second <= tccp_pkg::CC_RESET;
		end
		else if (cap_second)
		begin
			cc_reg_second <= up_counter;
		end
		else if (wr_cc_second)
		begin
			cc_reg_second <= reg_wdata;
		end
	end

	// Capture control bits; changing them mid-count is the user's risk
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			cc_control_reg <= tccp_pkg::CTRL_RESET;
		end
		else if (wr_control)
		begin
			cc_control_reg <= reg_wdata[2:0];
		end
	end

	// Edge-select codes held in the upper nibble of the prescaler byte
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			prescaler_mode_reg <= tccp_pkg::EDGE_RESET;
		end
		else if (wr_prescaler)
		begin
			prescaler_mode_reg <= reg_wdata[tccp_pkg::BIT_EDGE_FIRST_LO +: 4];
		end
	end

	// Pending capture events wait for the next count; a new capture in
	// the same cycle as the release keeps the flag set
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			cap_pend_first_reg <= 1'b0;
			cap_pend_second_reg <= 1'b0;
		end
		else if (!running)
		begin
			cap_pend_first_reg <= 1'b0;
			cap_pend_second_reg <= 1'b0;
		end
		else
		begin
			if (cap_first)
			begin
				cap_pend_first_reg <= 1'b1;
			end
			else if (count_tick)
			begin
				cap_pend_first_reg <= 1'b0;
			end
			if (cap_second)
			begin
				cap_pend_second_reg <= 1'b1;
			end
			else if (count_tick)
			begin
				cap_pend_second_reg <= 1'b0;
			end
		end
	end

	// Event pulses, one clock each and per register; a stop kills them
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			match_irq_first <= 1'b0;
			match_irq_second <= 1'b0;
		end
		else
		begin
			match_irq_first <= cmp_first ||
				(running && count_tick && cap_pend_first_reg);
			match_irq_second <= cmp_second ||
				(running && count_tick && cap_pend_second_reg);
		end
	end

	// Interval end: the first register's match in clear-on-match mode tells
	// the counter to restart; the counter itself is not touched here
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			interval_end <= 1'b0;
		end
		else
		begin
			interval_end <= cmp_first && (mode_hi == tccp_pkg::MODE_CLR_MATCH);
		end
	end

	// Note which capture register a read collides with a capture
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rd_first_hit_reg <= 1'b0;
			rd_second_hit_reg <= 1'b0;
		end
		else
		begin
			rd_first_hit_reg <= reg_rd && cap_first &&
				(reg_addr == tccp_pkg::OFS_CC_FIRST);
			rd_second_hit_reg <= reg_rd && cap_second &&
				(reg_addr == tccp_pkg::OFS_CC_SECOND);
		end
	end

	// Read mux; unmapped offsets return zero, reserved bits read zero.
	// Contents after a stop are whatever was last held, nothing more.
	always_comb
	begin
		rd_mux = 16'h0000;
		unique case (reg_addr)
			tccp_pkg::OFS_CC_FIRST: rd_mux = cc_reg_first;
			tccp_pkg::OFS_CC_SECOND: rd_mux = cc_reg_second;
			tccp_pkg::OFS_CC_CONTROL: rd_mux = {13'h0000, cc_control_reg};
			tccp_pkg::OFS_PRESCALER_MODE:
				rd_mux = {8'h00, prescaler_mode_reg, 4'h0};
			tccp_pkg::OFS_STATUS:
				rd_mux = {8'h00, rd_second_hit_reg, rd_first_hit_reg,
					second_level, first_level, cap_pend_second_reg,
					cap_pend_first_reg, running, wrapped_reg};
			default: rd_mux = 16'h0000;
		endcase
	end

	// Read data stand one cycle after the strobe and are zero otherwise;
	// a colliding read returns the pre-capture value, treated as undefined
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			reg_rdata <= 16'h0000;
		end
		else if (reg_rd)
		begin
			reg_rdata <= rd_mux;
		end
		else
		begin
			reg_rdata <= 16'h0000;
		end
	end
endmodule : tccp_top
`default_nettype wire

// ===== verif/tccp_props.sv
// Port-level checker for the capture/compare register pair
`timescale 1ns/1ns
`default_nettype none
module tccp_props (
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic [tccp_pkg::ADDR_W-1:0] reg_addr,
	input wire logic reg_rd,
	input wire logic [tccp_pkg::DATA_W-1:0] reg_rdata,
	input wire logic count_tick,
	input wire logic [2:0] timer_mode,
	input wire logic timer_out_level,
	input wire logic timer_out_en,
	input wire logic shared_port_pin_out,
	input wire logic shared_port_pin_oe,
	input wire logic match_irq_first,
	input wire logic match_irq_second,
	input wire logic interval_end
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!arst_n);

	// Event pulses last one clock each
	a_first_one_cycle: assert property (match_irq_first |=> !match_irq_first)
		else $error("first event longer than one cycle");
	a_second_one_cycle: assert property (match_irq_second |=> !match_irq_second)
		else $error("second event longer than one cycle");
	// Events only come one clock after a tick of a running counter
	a_first_after_tick: assert property (match_irq_first |->
		$past(count_tick) && $past(timer_mode[2:1]) != 2'h0)
		else $error("first event without a running tick");
	a_second_after_tick: assert property (match_irq_second |->
		$past(count_tick) && $past(timer_mode[2:1]) != 2'h0)
		else $error("second event without a running tick");
	// Interval end only with a first-register event in clear-on-match mode
	a_interval_mode: assert property (interval_end |->
		match_irq_first && $past(timer_mode[2:1]) == 2'h3)
		else $error("interval end outside clear-on-match");
	// A stopped timer stays silent
	a_stop_quiet: assert property ((timer_mode[2:1] == 2'h0) [*2] |=>
		!(match_irq_first || match_irq_second || interval_end))
		else $error("event while stopped");
	// Control and edge fields read back only their own bits
	a_ctrl_width: assert property (reg_rd && reg_addr == tccp_pkg::OFS_CC_CONTROL |=>
		reg_rdata[15:3] == 13'h0000)
		else $error("control read shows stray bits");
	a_edge_field: assert property (reg_rd && reg_addr == tccp_pkg::OFS_PRESCALER_MODE |=>
		reg_rdata[15:8] == 8'h00 && reg_rdata[3:0] == 4'h0)
		else $error("edge field read shows stray bits");
	// Shared pin is either an input or the timer output
	a_pin_input: assert property (!timer_out_en |-> !shared_port_pin_oe && !shared_port_pin_out)
		else $error("shared pin driven while an input");
	a_pin_drive: assert property (timer_out_en |->
		shared_port_pin_oe && shared_port_pin_out == timer_out_level)
		else $error("shared pin not driving timer level");

	c_first_event: cover property (match_irq_first);
	c_second_event: cover property (match_irq_second);
	c_interval: cover property (interval_end);
endmodule : tccp_props

bind tccp_top tccp_props u_props (.sys_clk(sys_clk), .arst_n(arst_n), .reg_addr(reg_addr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .count_tick(count_tick), .timer_mode(timer_mode),
	.timer_out_level(timer_out_level), .timer_out_en(timer_out_en),
	.shared_port_pin_out(shared_port_pin_out), .shared_port_pin_oe(shared_port_pin_oe),
	.match_irq_first(match_irq_first), .match_irq_second(match_irq_second),
	.interval_end(interval_end));
`default_nettype wire

// ===== verif/tccp_count_model.sv
// Up-counter model that feeds count and tick to the capture/compare pair
`timescale 1ns/1ns
`default_nettype none
module tccp_count_model (
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic [2:0] timer_mode,
	input wire logic interval_end,
	input wire logic load,
	input wire logic [15:0] load_val,
	output logic [15:0] up_counter,
	output logic count_tick
);
	logic [1:0] div_reg;

	// One tick in four clocks, so each count spans several cycles like a prescaled timer
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			div_reg <= 2'h0;
			count_tick <= 1'b0;
			up_counter <= 16'h0000;
		end
		else if (load || timer_mode[2:1] == 2'h0)
		begin
			div_reg <= 2'h0;
			count_tick <= 1'b0;
			up_counter <= load ? load_val : 16'h0000; // Stop restarts from zero
		end
		else
		begin
			div_reg <= div_reg + 2'h1;
			count_tick <= (div_reg == 2'h2);
			if (interval_end)
				up_counter <= 16'h0000; // Interval over, count clears
			else if (count_tick)
				up_counter <= up_counter + 16'h0001;
		end
	end
endmodule : tccp_count_model
`default_nettype wire

// ===== verif/timer_capture_compare_pair_tb.sv
// Self-checking bench for the capture/compare register pair
`timescale 1ns/1ns
`default_nettype none
module timer_capture_compare_pair_tb;
	typedef struct packed {logic [4:0] addr; logic [15:0] wdata; logic [15:0] exp;} tccp_row_t;
	localparam logic [4:0] A_CC1 = tccp_pkg::OFS_CC_FIRST;
	localparam logic [4:0] A_CC2 = tccp_pkg::OFS_CC_SECOND;
	localparam logic [4:0] A_CTL = tccp_pkg::OFS_CC_CONTROL;
	localparam logic [4:0] A_EDG = tccp_pkg::OFS_PRESCALER_MODE;
	logic sys_clk = 1'b0;
	logic arst_n = 1'b0;
	logic [4:0] reg_addr = 5'h00;
	logic [15:0] reg_wdata = 16'h0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [2:0] timer_mode = 3'h0;
	logic timer_input_first = 1'b0;
	logic shared_port_pin_in = 1'b0;
	logic timer_out_level = 1'b0;
	logic timer_out_en = 1'b0;
	logic load = 1'b0;
	logic [15:0] load_val = 16'h0000;
	logic [15:0] reg_rdata, up_counter, hit_cnt, d, c;
	logic count_tick, pin_out, pin_oe, irq1, irq2, ivl, seen, seen2;
	logic [2:0] ev = 3'h0;
	int err_count = 0;
	int tests_run = 0;
	// Readback rows, including an unmapped place
	tccp_row_t rows [5] = '{'{A_CC1, 16'h1234, 16'h1234}, '{A_CC2, 16'hABCD, 16'hABCD},
		'{A_CTL, 16'hFFFF, 16'h0007}, '{A_EDG, 16'hFFFF, 16'h00F0}, '{5'h14, 16'hFFFF, 16'h0000}};

	tccp_top uut (.sys_clk(sys_clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .up_counter(up_counter),
		.count_tick(count_tick), .timer_mode(timer_mode), .timer_input_first(timer_input_first),
		.shared_port_pin_in(shared_port_pin_in), .timer_out_level(timer_out_level),
		.timer_out_en(timer_out_en), .shared_port_pin_out(pin_out), .shared_port_pin_oe(pin_oe),
		.match_irq_first(irq1), .match_irq_second(irq2), .interval_end(ivl));
	tccp_count_model u_cnt (.sys_clk(sys_clk), .arst_n(arst_n), .timer_mode(timer_mode),
		.interval_end(ivl), .load(load), .load_val(load_val), .up_counter(up_counter),
		.count_tick(count_tick));

	// 125 MHz clock
	initial
	begin
		forever #4 sys_clk = ~sys_clk;
	end

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			err_count++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask : check

	task automatic check_range(input logic [15:0] got, input logic [15:0] lo, input logic [15:0] hi);
		tests_run++;
		if ((got >= lo && got <= hi) !== 1'b1)
		begin
			err_count++;
			$display("ERROR %0t got %h outside %h..%h", $time, got, lo, hi);
		end
	endtask : check_range

	// Always a full 16-bit word, never a partial write
	task automatic wr(input logic [4:0] a, input logic [15:0] v);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [4:0] a, output logic [15:0] v);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		@(negedge sys_clk);
		v = reg_rdata;
	endtask : rd

	// Mode 0 stops the counter, so every control and edge-select change is made stopped and restarts from zero
	task automatic run(input logic [2:0] m);
		@(posedge sys_clk);
		timer_mode <= m;
	endtask : run

	// Bounded watch for an event: 0 first, 1 second, 2 interval end.
	// Samples settle 1 ns after the edge, but the task hands back on a rising
	// edge so the caller's next pin drive lands on the clock
	task automatic wait_ev(input int sel, input int n, input bit must, output logic got);
		got = 1'b0;
		repeat (n)
		begin
			@(posedge sys_clk);
			#1;
			ev = {ivl, irq2, irq1};
			hit_cnt = up_counter;
			if (ev[sel] === 1'b1)
			begin
				got = 1'b1;
				break;
			end
		end
		if (must && !got)
		begin
			err_count++;
			$display("ERROR %0t event %0d missing", $time, sel);
			close_out();
		end
		@(posedge sys_clk);
	endtask : wait_ev

	task automatic close_out();
		$display("Comparisons %0d, mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : close_out

	initial
	begin
		repeat (12) @(posedge sys_clk);
		arst_n <= 1'b1;
		rd(A_CC1, d);
		check(d, 16'h0000);
		rd(A_CC2, d);
		check(d, 16'h0000);
		foreach (rows[i])
		begin
			wr(rows[i].addr, rows[i].wdata);
			rd(rows[i].addr, d);
			check(d, rows[i].exp);
		end
		wr(A_CTL, 16'h0000);
		wr(A_EDG, 16'h0000);
		// Both registers compare against a free-running count
		wr(A_CC1, 16'h0010);
		wr(A_CC2, 16'h0012);
		run(3'h2);
		wait_ev(0, 200, 1, seen);
		check(hit_cnt, 16'h0011);
		wait_ev(1, 40, 1, seen);
		check(hit_cnt, 16'h0013);
		// A value below the count waits for the wrap, a value ahead acts at once
		wr(A_CC1, 16'h0008);
		wait_ev(0, 60, 0, seen);
		check({15'h0000, seen}, 16'h0000);
		c = hit_cnt + 16'h0004;
		wr(A_CC1, c);
		wait_ev(0, 40, 1, seen);
		check(hit_cnt, c + 16'h0001);
		// Zero in both registers matches on 0 to 1 after a wrap
		run(3'h0);
		wr(A_CC1, 16'h0000);
		wr(A_CC2, 16'h0000);
		@(posedge sys_clk);
		load <= 1'b1;
		load_val <= 16'hFFFD;
		timer_mode <= 3'h2;
		@(posedge sys_clk);
		load <= 1'b0;
		wait_ev(0, 40, 1, seen);
		check(hit_cnt, 16'h0001);
		check({15'h0000, ev[1]}, 16'h0001);
		// Status shows the wrap flag and a running timer, nothing pending
		rd(tccp_pkg::OFS_STATUS, d);
		check(d, 16'h0003);
		// Interval timer with a nonzero length
		run(3'h0);
		wr(A_CC1, 16'h0006);
		run(3'h6);
		wait_ev(2, 60, 1, seen);
		check(hit_cnt, 16'h0007);
		@(posedge sys_clk);
		#1;
		check(up_counter, 16'h0000);
		// First register captures on the falling first input, code 01 reversed; the rising edge captures nothing
		run(3'h0);
		wr(A_CC2, 16'h5555);
		wr(A_CTL, 16'h0003);
		wr(A_EDG, 16'h0010);
		run(3'h2);
		timer_input_first <= 1'b1;
		wait_ev(0, 30, 0, seen);
		check({15'h0000, seen}, 16'h0000);
		c = hit_cnt;
		timer_input_first <= 1'b0;
		wait_ev(0, 40, 1, seen);
		rd(A_CC1, d);
		check_range(d, c, c + 16'h0003);
		rd(A_CC2, d);
		check(d, 16'h5555);
		// Both-edge code in reverse phase captures nothing
		run(3'h0);
		wr(A_EDG, 16'h0030);
		run(3'h2);
		timer_input_first <= 1'b1;
		wait_ev(0, 30, 0, seen);
		timer_input_first <= 1'b0;
		wait_ev(0, 30, 0, seen2);
		check({14'h0000, seen, seen2}, 16'h0000);
		// Second input captures directly, but not while the pin is the timer output
		run(3'h0);
		wr(A_CTL, 16'h0001);
		wr(A_EDG, 16'h0040);
		run(3'h2);
		shared_port_pin_in <= 1'b1;
		wait_ev(0, 40, 1, seen);
		check({15'h0000, seen}, 16'h0001);
		shared_port_pin_in <= 1'b0;
		timer_out_en <= 1'b1;
		timer_out_level <= 1'b1;
		wait_ev(0, 20, 0, seen);
		check({14'h0000, pin_oe, pin_out}, 16'h0003);
		shared_port_pin_in <= 1'b1;
		wait_ev(0, 30, 0, seen);
		check({15'h0000, seen}, 16'h0000);
		shared_port_pin_in <= 1'b0;
		wait_ev(0, 10, 0, seen);
		timer_out_en <= 1'b0;
		// Second register captures both edges of the first input
		run(3'h0);
		wr(A_CTL, 16'h0004);
		wr(A_EDG, 16'h0030);
		run(3'h2);
		timer_input_first <= 1'b1;
		wait_ev(1, 40, 1, seen);
		timer_input_first <= 1'b0;
		wait_ev(1, 40, 1, seen2);
		check({14'h0000, seen, seen2}, 16'h0003);
		// Mid-run reset while counting must clear both registers again
		wr(A_CC1, 16'h1357);
		@(posedge sys_clk);
		arst_n <= 1'b0;
		repeat (2) @(posedge sys_clk);
		arst_n <= 1'b1;
		rd(A_CC1, d);
		check(d, 16'h0000);
		rd(A_CC2, d);
		check(d, 16'h0000);
		close_out();
	end
endmodule : timer_capture_compare_pair_tb
`default_nettype wire
